// ---- char_lcd_refresh_cfg.svh ----
// Purpose: Constants for the character LCD refresh controller.
// Assumes: 50 MHz system clock, one 11-bit display RAM, 8-bit font ROM.
// Notes:   Offsets, counts and timing live here as macros only.
//
// Contract
// - Active-low select plus register select pick instruction or data register.
// - Panel is two halves, each 276 pixels wide and 64 lines.
// - Character cell is eight lines by six pixels; sixteen rows total.
// - Per column, emit top bit with bottom bit sixty-four lines lower.
// - After 276 bits, latch the line and advance row drivers.
// - Scan all 64 lines per half before restarting; one-in-64 duty.
// - RAM zero is top-left; bottom partner sits 368 higher, ninth row.
// - Fetch top then bottom, then advance RAM address by one.
// - Three-bit line counter forms high ROM address; zero on first line.
// - After 46 characters of a line, bump line counter and refetch.
// - Code goes on memory data lines, line count on high address lines.
// - RAM and ROM accesses alternate; never both selected.
// - Eleven address lines reach RAM; data captured while RAM selected.
// - Two serial streams: one top-half pixels, one bottom-half pixels.
// - Exactly 276 shift clocks per line, both streams together.
// - One latch clock pulse after a line loads the column latches.
// - Frame sync feeds row driver data and moves with each latch.
// - Polarity square wave reverses drive for zero net bias.
// - Whole panel refreshes at about 69 Hz, 14.5 ms per frame.
`ifndef CHAR_LCD_REFRESH_CFG_SVH
`define CHAR_LCD_REFRESH_CFG_SVH

// Panel geometry
`define CFG_LINE_CHARS    6'h2E
`define CFG_LAST_CHAR     6'h2D
`define CFG_CHAR_BITS     3'h6
`define CFG_BOT_OFS       11'h170
`define CFG_RAM_AW        11
`define CFG_ADDR_W        15
`define CFG_LCNT_POS      12

// Refresh timing
`define CFG_CLK_MHZ       50
`define CFG_FRAME_US      14500
`define CFG_HALF_LINES    64
`define CFG_LINE_CYCLES   ((`CFG_CLK_MHZ * `CFG_FRAME_US) / `CFG_HALF_LINES)

// Memory slot length and write-enable cycle within it, in system cycles
`define CFG_MEM_SLOT      2'h3
`define CFG_WE_SLOT       2'h1

// Latch pulse width in link cycles
`define CFG_LATCH_CYC     2'h2

// Instruction encoding, bits 7:6 of the instruction byte
`define CFG_INS_CTRL      2'h0
`define CFG_INS_PTR_HI    2'h1
`define CFG_INS_CTRL_ON   0
`define CFG_INS_CTRL_PLN  1
`define CFG_INS_PTR_LO    7

`endif

// ---- lcd_refresh_pkg.sv ----
// Purpose: Shared types for the character LCD refresh controller.
// Assumes: Constants come from the cfg header.
// Notes:   Types only.
`default_nettype none
package lcd_refresh_pkg;

    // Memory-side fetch sequencer
    typedef enum logic [2:0] {
        FS_IDLE,
        FS_RAM_TOP,
        FS_ROM_TOP,
        FS_RAM_BOT,
        FS_ROM_BOT,
        FS_SEND,
        FS_HOST_WR
    } fetch_state_t;

    // Link-side shifter
    typedef enum logic [1:0] {
        SS_WAIT,
        SS_LOW,
        SS_HIGH,
        SS_LATCH
    } shift_state_t;

endpackage : lcd_refresh_pkg
`default_nettype wire

// ---- cdc_word_handshake.sv ----
// Purpose: Toggle handshake carrying one word between two clocks.
// Assumes: Source holds the word register stable until acknowledged.
// Notes:   Destination reads the held word once request has synced.
`timescale 1ns/100ps
`default_nettype none
module cdc_word_handshake #(
    parameter int unsigned W = 13
) (
    // Source side
    input  wire logic         srcClk,
    input  wire logic         srcRst,
    input  wire logic         srcValid,
    output logic              srcReady,
    input  wire logic [W-1:0] srcData,
    // Destination side
    input  wire logic         dstClk,
    input  wire logic         dstRst,
    output logic              dstValid,
    input  wire logic         dstReady,
    output logic [W-1:0]      dstData
);

    logic         reqTog_q;
    logic         ackMeta_q;
    logic         ackSync_q;
    logic [W-1:0] word_q;
    logic         reqMeta_q;
    logic         reqSync_q;
    logic         ackTog_q;

    // Source: launch word, toggle request
    always_ff @(posedge srcClk or posedge srcRst) begin
        if (srcRst) begin
            reqTog_q <= 1'b0;
            word_q   <= '0;
        end else if (srcValid && srcReady) begin
            reqTog_q <= ~reqTog_q;
            word_q   <= srcData;
        end
    end

    // Source: acknowledge synchroniser
    always_ff @(posedge srcClk or posedge srcRst) begin
        if (srcRst) begin
            ackMeta_q <= 1'b0;
            ackSync_q <= 1'b0;
        end else begin
            ackMeta_q <= ackTog_q;
            ackSync_q <= ackMeta_q;
        end
    end

    assign srcReady = (reqTog_q == ackSync_q);

    // Destination: request synchroniser
    always_ff @(posedge dstClk or posedge dstRst) begin
        if (dstRst) begin
            reqMeta_q <= 1'b0;
            reqSync_q <= 1'b0;
        end else begin
            reqMeta_q <= reqTog_q;
            reqSync_q <= reqMeta_q;
        end
    end

    // Destination: acknowledge on take
    always_ff @(posedge dstClk or posedge dstRst) begin
        if (dstRst) begin
            ackTog_q <= 1'b0;
        end else if (dstValid && dstReady) begin
            ackTog_q <= reqSync_q;
        end
    end

    assign dstValid = (reqSync_q != ackTog_q);
    assign dstData  = word_q;

endmodule : cdc_word_handshake
`default_nettype wire

// ---- char_lcd_refresh_controller.sv ----
// Purpose: Refresh a split character LCD from display RAM and font ROM.
// Assumes: Memories answer within one slot; host writes only.
// Notes:   Fetch runs on clk, panel shifting runs on linkClk.
`timescale 1ns/100ps
`default_nettype none
`include "char_lcd_refresh_cfg.svh"
module char_lcd_refresh_controller #(
    parameter int unsigned LINE_CYCLES = `CFG_LINE_CYCLES,
    parameter int unsigned ADDR_W      = `CFG_ADDR_W
) (
    // System clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Panel link clock
    input  wire logic              linkClk,
    // Host write port
    input  wire logic              displayCtrlSelectN,
    input  wire logic              registerSelect,
    input  wire logic              hostWriteN,
    input  wire logic [7:0]        hostData,
    // Shared memory bus
    output logic [ADDR_W-1:0]      memAddrLine,
    input  wire logic [7:0]        memDataLineIn,
    output logic [7:0]             memDataLineOut,
    output logic                   memDataLineEnN,
    output logic                   ramSelectN,
    output logic                   ramWriteN,
    output logic                   romSelectN,
    input  wire logic [7:0]        romData,
    // Panel drivers
    output logic                   topPixelStream,
    output logic                   bottomPixelStream,
    output logic                   pixelShiftClock,
    output logic                   lineLatchClock,
    output logic                   frameSync,
    output logic                   polaritySquareWave
);
    import lcd_refresh_pkg::*;

    localparam int unsigned WORD_W = 13;

    // RAM address of a character cell
    function automatic logic [10:0] cellAddr(input logic [2:0] row,
                                             input logic [5:0] col);
        cellAddr = 11'({8'h00, row} * {5'h00, `CFG_LINE_CHARS}) + {5'h00, col};
    endfunction : cellAddr

    // Host input synchronisers
    logic [10:0]  hostMeta_q;
    logic [10:0]  hostSync_q;
    logic         strobePrev_q;
    logic         hostStrobe;
    logic         hostEvent;

    // Host visible state
    logic         displayOn_q;
    logic         polPerLine_q;
    logic [10:0]  hostPtr_q;
    logic [7:0]   wrData_q;
    logic         wrPending_q;

    // Refresh pacing
    logic [15:0]  lineTimer_q;
    logic         lineDue_q;
    logic [5:0]   lineIdx_q;
    logic [5:0]   col_q;

    // Fetch sequencer
    fetch_state_t fetchState_q;
    logic [1:0]   slotCnt_q;
    logic         slotEnd;
    logic         lineStart;
    logic         wrDone;
    logic [7:0]   charTop_q;
    logic [7:0]   charBot_q;
    logic [5:0]   bitsTop_q;
    logic [5:0]   bitsBot_q;

    // Memory bus next values
    logic [ADDR_W-1:0] memAddrD;
    logic [7:0]   memDataD;
    logic         memEnND;
    logic         ramSelND;
    logic         ramWrND;
    logic         romSelND;

    // Crossing
    logic         srcValid;
    logic         srcReady;
    logic [WORD_W-1:0] srcWord;
    logic         dstValid;
    logic         dstReady;
    logic [WORD_W-1:0] dstWord;

    // Link domain
    logic         rstLinkMeta_q;
    logic         rstLink_q;
    logic         plnMeta_q;
    logic         plnSync_q;
    shift_state_t shiftState_q;
    logic [5:0]   shTop_q;
    logic [5:0]   shBot_q;
    logic [2:0]   bitCnt_q;
    logic [5:0]   charCnt_q;
    logic         lineFirst_q;
    logic [1:0]   latchCnt_q;

    // Two-flop sync of host pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostMeta_q <= 11'h7FF;
            hostSync_q <= 11'h7FF;
        end else begin
            hostMeta_q <= {displayCtrlSelectN, registerSelect, hostWriteN, hostData};
            hostSync_q <= hostMeta_q;
        end
    end

    assign hostStrobe = ~hostSync_q[10] & ~hostSync_q[8];
    assign hostEvent  = hostStrobe & ~strobePrev_q;

    // Strobe edge detector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobePrev_q <= 1'b0;
        end else begin
            strobePrev_q <= hostStrobe;
        end
    end

    // Instruction register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            displayOn_q  <= 1'b0;
            polPerLine_q <= 1'b0;
        end else if (hostEvent && !hostSync_q[9]) begin
            if (hostSync_q[7:6] == `CFG_INS_CTRL) begin
                displayOn_q  <= hostSync_q[`CFG_INS_CTRL_ON];
                polPerLine_q <= hostSync_q[`CFG_INS_CTRL_PLN];
            end
        end
    end

    // Write pointer: set by instruction, bumped after each data write; instruction wins over bump
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostPtr_q <= 11'h000;
        end else if (hostEvent && !hostSync_q[9]) begin
            if (hostSync_q[`CFG_INS_PTR_LO]) begin
                hostPtr_q[6:0] <= hostSync_q[6:0];
            end else if (hostSync_q[7:6] == `CFG_INS_PTR_HI) begin
                hostPtr_q[10:7] <= hostSync_q[3:0];
            end
        end else if (wrDone) begin
            hostPtr_q <= hostPtr_q + 11'h001;
        end
    end

    // Data register write: new write wins over completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPending_q <= 1'b0;
            wrData_q    <= 8'h00;
        end else if (hostEvent && hostSync_q[9]) begin
            wrPending_q <= 1'b1;
            wrData_q    <= hostSync_q[7:0];
        end else if (wrDone) begin
            wrPending_q <= 1'b0;
        end
    end

    // Line period timer, 64 lines per 14.5 ms frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineTimer_q <= 16'h0000;
            lineDue_q   <= 1'b1;
        end else begin
            if (lineTimer_q == 16'(LINE_CYCLES - 1)) begin
                lineTimer_q <= 16'h0000;
                lineDue_q   <= 1'b1;
            end else begin
                lineTimer_q <= lineTimer_q + 16'h0001;
                if (lineStart) begin
                    lineDue_q <= 1'b0;
                end
            end
        end
    end

    assign slotEnd   = (slotCnt_q == `CFG_MEM_SLOT - 2'h1);
    assign lineStart = (fetchState_q == FS_IDLE) && lineDue_q;
    assign wrDone    = (fetchState_q == FS_HOST_WR) && slotEnd;
    assign srcValid  = (fetchState_q == FS_SEND);

    // Slot counter, restarts on every state change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slotCnt_q <= 2'h0;
        end else if (fetchState_q == FS_IDLE || fetchState_q == FS_SEND || slotEnd) begin
            slotCnt_q <= 2'h0;
        end else begin
            slotCnt_q <= slotCnt_q + 2'h1;
        end
    end

    // Fetch sequencer: RAM top, ROM top, RAM bottom, ROM bottom, send
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetchState_q <= FS_IDLE;
        end else begin
            case (fetchState_q)
                FS_IDLE: begin
                    if (lineDue_q) begin
                        fetchState_q <= FS_RAM_TOP;
                    end else if (wrPending_q) begin
                        fetchState_q <= FS_HOST_WR;
                    end
                end
                FS_RAM_TOP: if (slotEnd) fetchState_q <= FS_ROM_TOP;
                FS_ROM_TOP: if (slotEnd) fetchState_q <= FS_RAM_BOT;
                FS_RAM_BOT: if (slotEnd) fetchState_q <= FS_ROM_BOT;
                FS_ROM_BOT: if (slotEnd) fetchState_q <= FS_SEND;
                FS_SEND: begin
                    if (srcReady) begin
                        fetchState_q <= (col_q == `CFG_LAST_CHAR) ? FS_IDLE : FS_RAM_TOP;
                    end
                end
                FS_HOST_WR: if (slotEnd) fetchState_q <= FS_IDLE;
                default: fetchState_q <= FS_IDLE;
            endcase
        end
    end

    // Column and line counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            col_q     <= 6'h00;
            lineIdx_q <= 6'h00;
        end else if (fetchState_q == FS_SEND && srcReady) begin
            if (col_q == `CFG_LAST_CHAR) begin
                col_q     <= 6'h00;
                lineIdx_q <= lineIdx_q + 6'h01;
            end else begin
                col_q <= col_q + 6'h01;
            end
        end
    end

    // Capture codes and font bits at slot end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charTop_q <= 8'h00;
            charBot_q <= 8'h00;
            bitsTop_q <= 6'h00;
            bitsBot_q <= 6'h00;
        end else if (slotEnd) begin
            case (fetchState_q)
                FS_RAM_TOP: charTop_q <= memDataLineIn;
                FS_ROM_TOP: bitsTop_q <= displayOn_q ? romData[5:0] : 6'h00;
                FS_RAM_BOT: charBot_q <= memDataLineIn;
                FS_ROM_BOT: bitsBot_q <= displayOn_q ? romData[5:0] : 6'h00;
                default: ;
            endcase
        end
    end

    // Memory bus decode by state
    always_comb begin
        memAddrD = '0;
        memDataD = 8'h00;
        memEnND  = 1'b1;
        ramSelND = 1'b1;
        ramWrND  = 1'b1;
        romSelND = 1'b1;
        case (fetchState_q)
            FS_RAM_TOP: begin
                memAddrD = ADDR_W'(cellAddr(lineIdx_q[5:3], col_q));
                ramSelND = 1'b0;
            end
            FS_RAM_BOT: begin
                memAddrD = ADDR_W'(cellAddr(lineIdx_q[5:3], col_q) + `CFG_BOT_OFS);
                ramSelND = 1'b0;
            end
            FS_ROM_TOP, FS_ROM_BOT: begin
                memAddrD = ADDR_W'({lineIdx_q[2:0], 12'h000});
                memDataD = (fetchState_q == FS_ROM_TOP) ? charTop_q : charBot_q;
                memEnND  = 1'b0;
                romSelND = 1'b0;
            end
            FS_HOST_WR: begin
                memAddrD = ADDR_W'(hostPtr_q);
                memDataD = wrData_q;
                memEnND  = 1'b0;
                ramSelND = 1'b0;
                ramWrND  = (slotCnt_q != `CFG_WE_SLOT);
            end
            default: ;
        endcase
    end

    // Registered memory bus outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            memAddrLine    <= '0;
            memDataLineOut <= 8'h00;
            memDataLineEnN <= 1'b1;
            ramSelectN     <= 1'b1;
            ramWriteN      <= 1'b1;
            romSelectN     <= 1'b1;
        end else begin
            memAddrLine    <= memAddrD;
            memDataLineOut <= memDataD;
            memDataLineEnN <= memEnND;
            ramSelectN     <= ramSelND;
            ramWriteN      <= ramWrND;
            romSelectN     <= romSelND;
        end
    end

    // Word: frame-start flag, top bits, bottom bits
    assign srcWord = {(lineIdx_q == 6'h00) && (col_q == 6'h00), bitsTop_q, bitsBot_q};

    cdc_word_handshake #(
        .W        (WORD_W)
    ) u_xfer (
        .srcClk   (clk),
        .srcRst   (rst),
        .srcValid (srcValid),
        .srcReady (srcReady),
        .srcData  (srcWord),
        .dstClk   (linkClk),
        .dstRst   (rstLink_q),
        .dstValid (dstValid),
        .dstReady (dstReady),
        .dstData  (dstWord)
    );

    // Link reset: async assert, synced release
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            rstLinkMeta_q <= 1'b1;
            rstLink_q     <= 1'b1;
        end else begin
            rstLinkMeta_q <= 1'b0;
            rstLink_q     <= rstLinkMeta_q;
        end
    end

    // Polarity mode level into link domain
    always_ff @(posedge linkClk or posedge rstLink_q) begin
        if (rstLink_q) begin
            plnMeta_q <= 1'b0;
            plnSync_q <= 1'b0;
        end else begin
            plnMeta_q <= polPerLine_q;
            plnSync_q <= plnMeta_q;
        end
    end

    assign dstReady = (shiftState_q == SS_WAIT);

    // Shifter: six bits per character pair, 46 pairs per line
    always_ff @(posedge linkClk or posedge rstLink_q) begin
        if (rstLink_q) begin
            shiftState_q <= SS_WAIT;
            shTop_q      <= 6'h00;
            shBot_q      <= 6'h00;
            bitCnt_q     <= 3'h0;
            charCnt_q    <= 6'h00;
            lineFirst_q  <= 1'b0;
            latchCnt_q   <= 2'h0;
        end else begin
            case (shiftState_q)
                SS_WAIT: begin
                    if (dstValid) begin
                        shTop_q      <= dstWord[11:6];
                        shBot_q      <= dstWord[5:0];
                        bitCnt_q     <= `CFG_CHAR_BITS - 3'h1;
                        shiftState_q <= SS_LOW;
                        if (charCnt_q == 6'h00) begin
                            lineFirst_q <= dstWord[12];
                        end
                    end
                end
                SS_LOW: shiftState_q <= SS_HIGH;
                SS_HIGH: begin
                    if (bitCnt_q != 3'h0) begin
                        bitCnt_q     <= bitCnt_q - 3'h1;
                        shiftState_q <= SS_LOW;
                    end else if (charCnt_q == `CFG_LAST_CHAR) begin
                        charCnt_q    <= 6'h00;
                        latchCnt_q   <= 2'h0;
                        shiftState_q <= SS_LATCH;
                    end else begin
                        charCnt_q    <= charCnt_q + 6'h01;
                        shiftState_q <= SS_WAIT;
                    end
                end
                SS_LATCH: begin
                    latchCnt_q <= latchCnt_q + 2'h1;
                    if (latchCnt_q == `CFG_LATCH_CYC - 2'h1) begin
                        shiftState_q <= SS_WAIT;
                    end
                end
                default: shiftState_q <= SS_WAIT;
            endcase
        end
    end

    // Serial data and shift clock; data moves while clock is low
    always_ff @(posedge linkClk or posedge rstLink_q) begin
        if (rstLink_q) begin
            topPixelStream    <= 1'b0;
            bottomPixelStream <= 1'b0;
            pixelShiftClock   <= 1'b0;
        end else begin
            pixelShiftClock <= (shiftState_q == SS_LOW);
            if (shiftState_q == SS_WAIT && dstValid) begin
                topPixelStream    <= dstWord[11];
                bottomPixelStream <= dstWord[5];
            end else if (shiftState_q == SS_HIGH && bitCnt_q != 3'h0) begin
                topPixelStream    <= shTop_q[bitCnt_q - 3'h1];
                bottomPixelStream <= shBot_q[bitCnt_q - 3'h1];
            end
        end
    end

    // Latch pulse, frame marker and polarity
    always_ff @(posedge linkClk or posedge rstLink_q) begin
        if (rstLink_q) begin
            lineLatchClock     <= 1'b0;
            frameSync          <= 1'b0;
            polaritySquareWave <= 1'b0;
        end else begin
            lineLatchClock <= (shiftState_q == SS_LATCH);
            frameSync      <= (shiftState_q == SS_LATCH) && lineFirst_q;
            if (shiftState_q == SS_LATCH && latchCnt_q == 2'h0) begin
                if (plnSync_q || lineFirst_q) begin
                    polaritySquareWave <= ~polaritySquareWave;
                end
            end
        end
    end

endmodule : char_lcd_refresh_controller
`default_nettype wire

// ---- lcd_refresh_chk_assertions.sv ----
// Purpose: Port checks for the LCD refresh controller
// Assumes: Bound to the controller top
// Notes:   Memory checks on clk, panel checks on linkClk
`timescale 1ns/100ps
`default_nettype none
module lcd_refresh_chk #(parameter int unsigned ADDR_W = 15) (
    // Clocks and reset
    input wire logic              clk, rst, linkClk,
    // Memory bus
    input wire logic [ADDR_W-1:0] memAddrLine,
    input wire logic              ramSelectN, romSelectN,
    // Panel
    input wire logic              topPixelStream, bottomPixelStream, pixelShiftClock,
    input wire logic              lineLatchClock, frameSync, polaritySquareWave
);
    logic [8:0] shiftCnt_q;
    // Shift clocks since the last latch
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) shiftCnt_q <= 9'h000;
        else if (lineLatchClock) shiftCnt_q <= 9'h000;
        else if (pixelShiftClock) shiftCnt_q <= shiftCnt_q + 9'h001;
    end
    mem_excl_a: assert property (@(posedge clk) disable iff (rst)
        ramSelectN || romSelectN) else $error("both memories selected");
    rom_addr_a: assert property (@(posedge clk) disable iff (rst)
        !romSelectN |-> memAddrLine[11:0] == 12'h000) else $error("font address low bits");
    latch_width_a: assert property (@(posedge linkClk) disable iff (rst)
        $rose(lineLatchClock) |=> lineLatchClock ##1 !lineLatchClock) else $error("latch width");
    sync_latch_a: assert property (@(posedge linkClk) disable iff (rst)
        frameSync |-> lineLatchClock) else $error("frame sync outside latch");
    shift_pulse_a: assert property (@(posedge linkClk) disable iff (rst)
        pixelShiftClock |=> !pixelShiftClock) else $error("shift clock width");
    data_stable_a: assert property (@(posedge linkClk) disable iff (rst)
        pixelShiftClock |-> $stable({topPixelStream, bottomPixelStream})) else $error("data moved");
    pol_change_a: assert property (@(posedge linkClk) disable iff (rst)
        $changed(polaritySquareWave) |-> $rose(lineLatchClock)) else $error("polarity moved");
    shift_count_a: assert property (@(posedge linkClk) disable iff (rst)
        $rose(lineLatchClock) |-> shiftCnt_q == 9'h114) else $error("bits per line");
endmodule : lcd_refresh_chk
bind char_lcd_refresh_controller lcd_refresh_chk #(.ADDR_W(ADDR_W)) lcd_refresh_chk_inst (
    .clk, .rst, .linkClk, .memAddrLine, .ramSelectN, .romSelectN, .topPixelStream,
    .bottomPixelStream, .pixelShiftClock, .lineLatchClock, .frameSync, .polaritySquareWave);
`default_nettype wire

// ---- lcd_panel_model.sv ----
// Purpose: Column and row driver chain of the panel
// Assumes: Panel clocks seen as levels at linkClk
// Notes:   Reports latched cells and row marker
`timescale 1ns/100ps
`default_nettype none
module lcd_panel_model (
    // Clock and reset
    input  wire logic linkClk, rst,
    // Panel inputs
    input  wire logic topPixelStream, bottomPixelStream,
    input  wire logic pixelShiftClock, lineLatchClock, frameSync,
    // Observed state
    output logic [275:0] topCells, botCells,
    output logic [15:0]  rowMarks,
    output logic [7:0]   nLatch
);
    logic [275:0] topSr_q, botSr_q;
    logic         shPrev_q, laPrev_q;
    // Shift chains, cell latches, row marker
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            {topSr_q, botSr_q, topCells, botCells, rowMarks, nLatch, shPrev_q, laPrev_q} <= '0;
        end else begin
            shPrev_q <= pixelShiftClock;
            laPrev_q <= lineLatchClock;
            if (pixelShiftClock && !shPrev_q) begin // chained column registers
                topSr_q <= {topSr_q[274:0], topPixelStream};
                botSr_q <= {botSr_q[274:0], bottomPixelStream};
            end
            if (lineLatchClock && !laPrev_q) begin
                topCells <= topSr_q;
                botCells <= botSr_q;
                rowMarks <= {rowMarks[14:0], frameSync};
                nLatch <= nLatch + 8'h01;
            end
        end
    end
endmodule : lcd_panel_model
`default_nettype wire

// ---- char_lcd_refresh_controller_test.sv ----
// Purpose: Self-checking bench for the LCD refresh controller
// Assumes: Bench plays display RAM and font ROM
// Notes:   Short line period keeps the run brief
`timescale 1ns/100ps
`default_nettype none
module char_lcd_refresh_controller_test;
    typedef struct {logic [7:0] latchNo; logic [2:0] line;} row_t;
    row_t rows [4] = '{'{8'h01, 3'h1}, '{8'h02, 3'h2}, '{8'h07, 3'h7}, '{8'h08, 3'h0}};
    logic clk = 0, linkClk = 0, rst = 1, displayCtrlSelectN = 1, registerSelect = 0;
    logic hostWriteN = 1, memDataLineEnN, ramSelectN, ramWriteN, romSelectN, frameSync;
    logic topPixelStream, bottomPixelStream, pixelShiftClock, lineLatchClock, polaritySquareWave;
    logic [7:0] hostData = 8'h00, memDataLineIn = 8'h00, romData = 8'h00, memDataLineOut, nLatch;
    logic [14:0] memAddrLine;
    logic [275:0] topCells, botCells;
    logic [15:0] rowMarks;
    int n_mismatch = 0, compares = 0;
    always #10 clk = ~clk;
    always #3 linkClk = ~linkClk;
    // RAM code is address bit 8, which marks the bottom half of the first two rows; ROM returns all ones for marked codes, else line count
    always @(posedge clk) begin
        memDataLineIn <= ramSelectN ? ~memDataLineIn : {7'h00, memAddrLine[8]};
        romData <= romSelectN ? ~romData
                 : (memDataLineOut[0] ? 8'h3F : {5'h00, memAddrLine[14:12]});
    end
    char_lcd_refresh_controller #(.LINE_CYCLES(2000)) char_lcd_refresh_controller_inst (
        .clk, .rst, .linkClk, .displayCtrlSelectN, .registerSelect, .hostWriteN, .hostData,
        .memAddrLine, .memDataLineIn, .memDataLineOut, .memDataLineEnN, .ramSelectN,
        .ramWriteN, .romSelectN, .romData, .topPixelStream, .bottomPixelStream,
        .pixelShiftClock, .lineLatchClock, .frameSync, .polaritySquareWave);
    lcd_panel_model lcd_panel_model_inst (.linkClk, .rst, .topPixelStream, .bottomPixelStream,
        .pixelShiftClock, .lineLatchClock, .frameSync, .topCells, .botCells, .rowMarks, .nLatch);
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic cmpVec(input string name, input logic [275:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : cmpVec
    // Bounded wait for a latch count
    task automatic waitLatch(input logic [7:0] target);
        for (int i = 0; i < 25000 && nLatch !== target; i++) @(posedge clk);
        cmpVec("latch count", 276'(target), 276'(nLatch));
        if (nLatch !== target) complete_run();
    endtask : waitLatch
    initial begin
        repeat (8) @(posedge clk);
        cmpVec("reset", 276'(8'hF0), 276'({ramSelectN, romSelectN, ramWriteN, memDataLineEnN,
               pixelShiftClock, lineLatchClock, frameSync, polaritySquareWave}));
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        // Instruction write: display on
        displayCtrlSelectN <= 1'b0;
        hostWriteN <= 1'b0;
        hostData <= 8'h01;
        repeat (4) @(posedge clk);
        displayCtrlSelectN <= 1'b1;
        hostWriteN <= 1'b1;
        // Latched lines against row table
        foreach (rows[k]) begin
            waitLatch(rows[k].latchNo + 8'h01);
            cmpVec("top", 276'({46{3'h0, rows[k].line}}), topCells);
            cmpVec("bottom", {276{1'b1}}, botCells);
        end
        cmpVec("row marks", 276'(16'h0100), 276'(rowMarks));
        cmpVec("polarity", 276'(1'b1), 276'(polaritySquareWave));
        complete_run();
    end
endmodule : char_lcd_refresh_controller_test
`default_nettype wire
